// ==== rtl/adcs_top.sv ====
`timescale 1ns/1ps
// What this block does
// - Result high byte upper eight, low byte two
// - Result bits five to zero read zero
// - Inputs n and n+4 share a register
// - Result registers cleared on reset, standby
// - High byte direct, low byte via holding
// - Control/status clears on reset and standby
// - End flag set at single or scan end
// - End flag cleared by zero after read
// - Bit six enables end interrupt
// - Start set by software, pin, timer
// - Start holds while busy, single clears it
// - Scan cycles until start cleared
// - Bit four selects single or scan
// - Bit three selects 134 or 70 states
// - Channel bits pick group and index
// - Dedicated external trigger input pin
// - Pin and timer starts need trigger enable
// - Interrupt while end flag and enable set
// - High-byte read loads holding register
// - Scan starts first, advances, wraps
module adcs_top (
    // Clock, reset, standby
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        standby_i,
    // CPU 8-bit register port
    input  wire logic [19:0] cpu_addr_i,
    input  wire logic        cpu_rd_i,
    input  wire logic        cpu_wr_i,
    input  wire logic [7:0]  cpu_wdata_i,
    output logic [7:0]       cpu_rdata_o,
    // Start sources
    input  wire logic        ext_trigger_pin_i,
    input  wire logic        timer_match_i,
    // Analog core handshake
    output logic             core_start_o,
    output logic [2:0]       core_channel_o,
    output logic             core_fast_o,
    input  wire logic        core_done_i,
    input  wire logic [9:0]  core_result_i,
    // Interrupt request
    output logic             conv_end_irq_o
);
    import adcs_pkg::*;

    logic              conv_end_flag;
    logic              end_irq_enable;
    logic              conv_start_bit;
    logic              scan_mode;
    logic              conv_time_select;
    logic [2:0]        channel_sel;
    logic              trigger_enable;
    logic              trig_spare;
    logic              flag_seen_one;
    logic [7:0]        holding_low;
    logic [1:0]        scan_index;
    adcs_state_t       state;
    logic              trig_fall;
    logic [3:0]        load_vec;
    logic [15:0]       result_val [NUM_RESULTS];
    logic              hw_start;
    logic              last_channel;
    logic              conv_done;
    logic              ctrl_wr;
    logic              ctrl_rd;
    logic [7:0]        ctrl_rdata;
    logic [7:0]        trig_rdata;
    logic [1:0]        active_index;
    logic [7:0]        next_rdata;

    adcs_sync u_trig_sync (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .async_i    (ext_trigger_pin_i),
        .fall_o     (trig_fall)
    );

    genvar g;
    generate
        for (g = 0; g < NUM_RESULTS; g++) begin : gen_result
            adcs_result_reg u_result (
                .core_clk_i (core_clk_i),
                .srst_i     (srst_i),
                .standby_i  (standby_i),
                .load_i     (load_vec[g]),
                .data_i     (core_result_i),
                .value_o    (result_val[g])
            );
        end
    endgenerate

    assign ctrl_wr = cpu_wr_i && (cpu_addr_i == ADDR_CONV_CTRL);
    assign ctrl_rd = cpu_rd_i && (cpu_addr_i == ADDR_CONV_CTRL);
    assign hw_start = trigger_enable && (trig_fall || timer_match_i);
    assign conv_done = (state == ADCS_WAIT) && core_done_i;
    // Single mode converts the indexed input; scan runs from index 0 upward
    assign active_index = scan_mode ? scan_index : channel_sel[1:0];
    assign last_channel = !scan_mode || (scan_index == channel_sel[1:0]);

    always_comb begin
        load_vec = 4'h0;
        if (conv_done) begin
            load_vec[active_index] = 1'b1;
        end
    end

    // Software clear only after the flag was observed as one
    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i) begin
            flag_seen_one <= 1'b0;
        end else if (ctrl_rd && conv_end_flag) begin
            flag_seen_one <= 1'b1;
        end else if (ctrl_wr && !cpu_wdata_i[BIT_END_FLAG]) begin
            flag_seen_one <= 1'b0;
        end
    end

    // End flag: a hardware set in the same cycle as a clear wins
    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i) begin
            conv_end_flag <= CONV_CTRL_RESET[BIT_END_FLAG];
        end else if (conv_done && last_channel) begin
            conv_end_flag <= 1'b1;
        end else if (ctrl_wr && !cpu_wdata_i[BIT_END_FLAG] && flag_seen_one) begin
            conv_end_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i) begin
            end_irq_enable   <= CONV_CTRL_RESET[BIT_IRQ_ENABLE];
            scan_mode        <= CONV_CTRL_RESET[BIT_SCAN];
            conv_time_select <= CONV_CTRL_RESET[BIT_TIME_SELECT];
            channel_sel      <= CONV_CTRL_RESET[2:0];
        end else if (ctrl_wr) begin
            end_irq_enable   <= cpu_wdata_i[BIT_IRQ_ENABLE];
            scan_mode        <= cpu_wdata_i[BIT_SCAN];
            conv_time_select <= cpu_wdata_i[BIT_TIME_SELECT];
            channel_sel      <= cpu_wdata_i[2:0];
        end
    end

    // Start bit: software write, trigger sources, auto clear in single mode
    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i) begin
            conv_start_bit <= CONV_CTRL_RESET[BIT_START];
        end else if (hw_start) begin
            conv_start_bit <= 1'b1;
        end else if (ctrl_wr) begin
            conv_start_bit <= cpu_wdata_i[BIT_START];
        end else if (conv_done && !scan_mode) begin
            conv_start_bit <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i) begin
            trigger_enable <= TRIG_CTRL_RESET[BIT_TRIG_ENABLE];
            trig_spare     <= TRIG_CTRL_RESET[BIT_TRIG_SPARE];
        end else if (cpu_wr_i && (cpu_addr_i == ADDR_TRIG_CTRL)) begin
            trigger_enable <= cpu_wdata_i[BIT_TRIG_ENABLE];
            trig_spare     <= cpu_wdata_i[BIT_TRIG_SPARE];
        end
    end

    // Sequencer: relies on software halting before reconfiguring
    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i || !conv_start_bit) begin
            state      <= ADCS_IDLE;
            scan_index <= 2'b00;
        end else begin
            case (state)
                ADCS_IDLE: begin
                    state <= ADCS_START;
                end
                ADCS_START: begin
                    state <= ADCS_WAIT;
                end
                ADCS_WAIT: begin
                    if (core_done_i) begin
                        if (!scan_mode) begin
                            state <= ADCS_IDLE;
                        end else begin
                            state <= ADCS_START;
                            scan_index <= last_channel ? 2'b00 : scan_index + 2'b01;
                        end
                    end
                end
                default: begin
                    state <= ADCS_IDLE;
                end
            endcase
        end
    end

    // Core strobe and channel, registered
    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i) begin
            core_start_o   <= 1'b0;
            core_channel_o <= 3'h0;
            core_fast_o    <= 1'b0;
        end else begin
            core_start_o   <= (state == ADCS_START) && conv_start_bit;
            core_channel_o <= {channel_sel[BIT_GROUP], active_index};
            core_fast_o    <= conv_time_select;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i) begin
            conv_end_irq_o <= 1'b0;
        end else begin
            conv_end_irq_o <= conv_end_flag && end_irq_enable;
        end
    end

    // Holding register loaded by the high-byte read
    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i) begin
            holding_low <= 8'h00;
        end else if (cpu_rd_i && ((cpu_addr_i & ADDR_RESULT_MASK) == ADDR_RESULT_BASE)
                     && !cpu_addr_i[0]) begin
            holding_low <= result_val[cpu_addr_i[2:1]][7:0];
        end
    end

    assign ctrl_rdata = {conv_end_flag, end_irq_enable, conv_start_bit, scan_mode,
                         conv_time_select, channel_sel};
    assign trig_rdata = {trigger_enable, TRIG_CTRL_ONES[6:1], trig_spare};

    always_comb begin
        next_rdata = 8'h00;
        if ((cpu_addr_i & ADDR_RESULT_MASK) == ADDR_RESULT_BASE) begin
            if (!cpu_addr_i[0]) begin
                next_rdata = result_val[cpu_addr_i[2:1]][15:8];
            end else begin
                next_rdata = holding_low;
            end
        end else if (cpu_addr_i == ADDR_CONV_CTRL) begin
            next_rdata = ctrl_rdata;
        end else if (cpu_addr_i == ADDR_TRIG_CTRL) begin
            next_rdata = trig_rdata;
        end
    end

    // Read data appears the cycle after the strobe
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cpu_rdata_o <= 8'h00;
        end else if (cpu_rd_i) begin
            cpu_rdata_o <= next_rdata;
        end
    end
endmodule

// ==== rtl/adcs_pkg.sv ====
package adcs_pkg;
    // Register offsets (low 20 bits of the CPU address)
    localparam logic [19:0] ADDR_RESULT_A_HIGH = 20'hFFFE0;
    localparam logic [19:0] ADDR_RESULT_A_LOW  = 20'hFFFE1;
    localparam logic [19:0] ADDR_RESULT_B_HIGH = 20'hFFFE2;
    localparam logic [19:0] ADDR_RESULT_B_LOW  = 20'hFFFE3;
    localparam logic [19:0] ADDR_RESULT_C_HIGH = 20'hFFFE4;
    localparam logic [19:0] ADDR_RESULT_C_LOW  = 20'hFFFE5;
    localparam logic [19:0] ADDR_RESULT_D_HIGH = 20'hFFFE6;
    localparam logic [19:0] ADDR_RESULT_D_LOW  = 20'hFFFE7;
    localparam logic [19:0] ADDR_CONV_CTRL     = 20'hFFFE8;
    localparam logic [19:0] ADDR_TRIG_CTRL     = 20'hFFFE9;
    localparam logic [19:0] ADDR_RESULT_BASE   = 20'hFFFE0;
    localparam logic [19:0] ADDR_RESULT_MASK   = 20'hFFFF8;

    // Control/status fields
    localparam int BIT_END_FLAG    = 7;
    localparam int BIT_IRQ_ENABLE  = 6;
    localparam int BIT_START       = 5;
    localparam int BIT_SCAN        = 4;
    localparam int BIT_TIME_SELECT = 3;
    localparam int BIT_GROUP       = 2;
    localparam int BIT_TRIG_ENABLE = 7;
    localparam int BIT_TRIG_SPARE  = 0;

    localparam logic [7:0] CONV_CTRL_RESET   = 8'h00;
    localparam logic [7:0] TRIG_CTRL_RESET   = 8'h7E;
    localparam logic [7:0] TRIG_CTRL_ONES    = 8'h7E;
    localparam logic [15:0] RESULT_RESET     = 16'h0000;

    // Conversion times in states (system clock cycles)
    localparam int CONV_STATES_SLOW = 134;
    localparam int CONV_STATES_FAST = 70;
    localparam real CLK_PERIOD_NS   = 5.0;

    localparam int RESULT_BITS  = 10;
    localparam int NUM_RESULTS  = 4;

    typedef enum logic [1:0] {
        ADCS_IDLE  = 2'b00,
        ADCS_START = 2'b01,
        ADCS_WAIT  = 2'b10
    } adcs_state_t;
endpackage

// ==== rtl/adcs_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser with falling-edge detect after the second stage
module adcs_sync (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic srst_i,
    // Pin side
    input  wire logic async_i,
    // Synchronous side
    output logic      fall_o
);
    logic meta;
    logic sync;
    logic sync_d;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            meta   <= 1'b1;
            sync   <= 1'b1;
            sync_d <= 1'b1;
        end else begin
            meta   <= async_i;
            sync   <= meta;
            sync_d <= sync;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            fall_o <= 1'b0;
        end else begin
            fall_o <= sync_d & ~sync;
        end
    end
endmodule

// ==== rtl/adcs_result_reg.sv ====
`timescale 1ns/1ps
// One 16-bit result register, left justified, low six bits zero
module adcs_result_reg (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       srst_i,
    input  wire logic       standby_i,
    // Load port
    input  wire logic       load_i,
    input  wire logic [9:0] data_i,
    // Contents
    output logic [15:0]     value_o
);
    import adcs_pkg::*;

    always_ff @(posedge core_clk_i) begin
        if (srst_i || standby_i) begin
            value_o <= RESULT_RESET;
        end else if (load_i) begin
            value_o <= {data_i, 6'h00};
        end
    end
endmodule

// ==== test/adcs_core_model.sv ====
`timescale 1ns/1ps
// Stand-in for the analog converter core
module adcs_core_model #(
    parameter int DLY = 6
) (
    // Clock
    input  wire logic       core_clk_i,
    // Handshake with the sequencer
    input  wire logic       core_start_i,
    input  wire logic [2:0] core_channel_i,
    output logic            core_done_o,
    output logic [9:0]      core_result_o
);
    int cnt = 0;
    initial begin
        core_done_o = 1'b0;
        core_result_o = 10'h155;
    end
    // Result encodes the channel; bus toggles when not valid
    always @(posedge core_clk_i) begin
        core_done_o <= 1'b0;
        core_result_o <= ~core_result_o;
        if (core_start_i) cnt <= DLY;
        else if (cnt > 0) cnt <= cnt - 1;
        if (cnt == 1 && !core_start_i) begin
            core_done_o <= 1'b1;
            core_result_o <= {core_channel_i, core_channel_i, core_channel_i, 1'b1};
        end
    end
endmodule

// ==== test/adcs_top_props.sv ====
`timescale 1ns/1ps
module adcs_top_props (
    // Watched ports
    input wire logic        core_clk_i,
    input wire logic        srst_i,
    input wire logic        standby_i,
    input wire logic [19:0] cpu_addr_i,
    input wire logic        cpu_rd_i,
    input wire logic        cpu_wr_i,
    input wire logic [7:0]  cpu_rdata_o,
    input wire logic        core_start_o,
    input wire logic        core_done_i,
    input wire logic        conv_end_irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    property p_rst_quiet; $fell(srst_i) |-> !core_start_o && !conv_end_irq_o && cpu_rdata_o == 8'h00; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle after reset");
    property p_start_gap; core_start_o |=> !core_start_o [*3]; endproperty
    a_start_gap: assert property (p_start_gap) else $error("start strobe too long");
    property p_irq_cause; $rose(conv_end_irq_o) |-> $past(core_done_i, 2) || $past(cpu_wr_i, 2); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
    property p_irq_drop; $fell(conv_end_irq_o) |-> $past(cpu_wr_i, 2) || $past(standby_i); endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("interrupt dropped by itself");
    property p_rdata_hold; !cpu_rd_i |=> $stable(cpu_rdata_o); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_unmapped; cpu_rd_i && (cpu_addr_i < 20'hFFFE0 || cpu_addr_i > 20'hFFFE9) |=> cpu_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_low_zero; cpu_rd_i && cpu_addr_i[0] && cpu_addr_i[19:3] == 17'h1FFFC |=> cpu_rdata_o[5:0] == 6'h00;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("reserved result bits set");
    property p_trig_ones; cpu_rd_i && cpu_addr_i == 20'hFFFE9 |=> cpu_rdata_o[6:1] == 6'h3F; endproperty
    a_trig_ones: assert property (p_trig_ones) else $error("trigger spare bits not one");
    c_start: cover property (core_start_o);
    c_irq: cover property ($rose(conv_end_irq_o));
    c_scan: cover property (core_done_i ##2 core_start_o);
endmodule
bind adcs_top adcs_top_props adcs_top_props_inst (.*);

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import adcs_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        standby_i = 1'b0;
    logic [19:0] cpu_addr_i = 20'h00000;
    logic        cpu_rd_i = 1'b0;
    logic        cpu_wr_i = 1'b0;
    logic [7:0]  cpu_wdata_i = 8'h00;
    logic        ext_trigger_pin_i = 1'b1;
    logic        timer_match_i = 1'b0;
    logic        core_done_i;
    logic [9:0]  core_result_i;
    logic [7:0]  cpu_rdata_o;
    logic        core_start_o;
    logic [2:0]  core_channel_o;
    logic        core_fast_o;
    logic        conv_end_irq_o;
    logic [7:0]  d;
    logic [7:0]  m;
    logic [2:0]  ch;
    logic [2:0]  chans[$];
    int          err_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          nch;
    int          n;
    adcs_top adcs_top_inst (.*);
    adcs_core_model adcs_core_model_inst (.core_clk_i(core_clk_i), .core_start_i(core_start_o),
        .core_channel_i(core_channel_o), .core_done_o(core_done_i), .core_result_o(core_result_i));
    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (core_start_o === 1'b1) chans.push_back(core_channel_o);
        if (cycles == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge core_clk_i);
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] v);
        tick(1);
        cpu_addr_i = a;
        cpu_wdata_i = v;
        cpu_wr_i = 1'b1;
        tick(1);
        cpu_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, output logic [7:0] v);
        tick(1);
        cpu_addr_i = a;
        cpu_rd_i = 1'b1;
        tick(1);
        cpu_rd_i = 1'b0;
        v = cpu_rdata_o;
    endtask
    task automatic rc(input logic [19:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v, e);
    endtask
    task automatic wait_flag(output logic [7:0] v);
        for (int i = 0; i < 100; i++) begin
            rd(ADDR_CONV_CTRL, v);
            if (v[BIT_END_FLAG] === 1'b1) break;
        end
    endtask
    task automatic chk_res(input logic [2:0] c);
        logic [9:0]  r;
        logic [19:0] a;
        r = {c, c, c, 1'b1};
        a = ADDR_RESULT_A_HIGH + {17'h00000, c[1:0], 1'b0};
        rc(a, r[9:2]);
        rc(a + 20'h00001, {r[1:0], 6'h00});
    endtask
    task automatic pulse_timer;
        tick(1);
        timer_match_i = 1'b1;
        tick(1);
        timer_match_i = 1'b0;
    endtask
    initial begin
        tick(5);
        srst_i = 1'b0;
        for (int i = 0; i < 11; i++) rc(ADDR_RESULT_A_HIGH + 20'(i), i == 9 ? TRIG_CTRL_RESET : 8'h00);
        $display("test reset values done");
        for (int c = 0; c < 8; c++) begin
            ch = 3'(c);
            m = {1'b0, ch[1], 1'b1, 1'b0, ch[0], ch};
            wr(ADDR_CONV_CTRL, m);
            tick(1);
            chk({7'h00, core_fast_o}, {7'h00, ch[0]});
            rc(ADDR_CONV_CTRL, m);
            wait_flag(d);
            chk(d, m ^ 8'hA0);
            chk({7'h00, conv_end_irq_o}, {7'h00, ch[1]});
            wr(ADDR_CONV_CTRL, m ^ 8'hA0);
            rc(ADDR_CONV_CTRL, m ^ 8'hA0);
            wr(ADDR_CONV_CTRL, m ^ 8'h20);
            rc(ADDR_CONV_CTRL, m ^ 8'h20);
            chk({7'h00, conv_end_irq_o}, 8'h00);
            chk_res(ch);
        end
        $display("test single mode done");
        for (int g = 0; g < 2; g++) begin
            chans = {};
            m = g ? 8'h37 : 8'h32;
            nch = 3 + g;
            wr(ADDR_CONV_CTRL, m);
            wait_flag(d);
            chk(d, m | 8'h80);
            // Stop before the next setup change
            wr(ADDR_CONV_CTRL, m & 8'h5F);
            tick(20);
            n = chans.size();
            tick(20);
            chk(8'(chans.size()), 8'(n));
            for (int i = 0; i <= nch; i++) chk(8'(chans[i]), 8'(g * 4 + i % nch));
            for (int i = 0; i < nch; i++) chk_res(3'(g * 4 + i));
        end
        $display("test scan mode done");
        wr(ADDR_CONV_CTRL, 8'h01);
        wr(ADDR_TRIG_CTRL, 8'h00);
        pulse_timer();
        // Pin edge must be ignored as well while triggers are disabled
        ext_trigger_pin_i = 1'b0;
        tick(2);
        ext_trigger_pin_i = 1'b1;
        tick(20);
        rc(ADDR_CONV_CTRL, 8'h01);
        wr(ADDR_TRIG_CTRL, 8'h81);
        rc(ADDR_TRIG_CTRL, 8'hFF);
        pulse_timer();
        // Zero written to the end flag before any read of it must not clear it
        tick(40);
        wr(ADDR_CONV_CTRL, 8'h01);
        wait_flag(d);
        chk(d, 8'h81);
        wr(ADDR_CONV_CTRL, 8'h01);
        tick(1);
        ext_trigger_pin_i = 1'b0;
        wait_flag(d);
        chk(d, 8'h81);
        ext_trigger_pin_i = 1'b1;
        $display("test triggers done");
        wr(ADDR_RESULT_B_HIGH, 8'hFF);
        chk_res(3'h1);
        tick(1);
        standby_i = 1'b1;
        tick(2);
        standby_i = 1'b0;
        rc(ADDR_RESULT_B_HIGH, 8'h00);
        rc(ADDR_CONV_CTRL, CONV_CTRL_RESET);
        rc(ADDR_TRIG_CTRL, TRIG_CTRL_RESET);
        $display("test standby done");
        wrap_up();
    end
endmodule
